// ===== bscr_responder.sv
// Bus snoop coherency responder for a copy-back data cache
`timescale 1ns/1ps
`include "bscr_cfg.svh"

// Functional notes
// - Sample at transfer start; global qualifies snoop
// - Active reservation qualifies write or kill codes
// - Check address parity on every snooped transfer
// - Snoop L1, L2 tags and queues; no icache
// - Retry global access to line being filled
// - Retry access to queued, ungranted write-back line
// - Modified hit (except write-kill) or collision raises retry; master retries later
// - Internal conflict may also raise retry
// - No retry once own write address completed
// - Own burst writes are non-global
// - Never retry non-global; reservations still checked
// - No-action codes cause no snoop action
// - Kill: E to I; M retry, push, I
// - Write-flush: E to I; M retry, push, I
// - Write-kill: hit to I, no retry
// - Read: single keeps E; burst invalidates
// - Intent-modify read: E to I; M pushed
// - Atomic write-flush also cancels any reservation
// - Atomic reads behave like their plain forms
// - No-cache read: E stays; M pushed to E
// - Single-beat reads count as caching inhibited
module bscr_responder #(
    parameter int AW = `BSCR_ADDR_W,
    parameter int PW = `BSCR_PAR_W,
    parameter int BL = `BSCR_BLK_LSB
) (
    input wire logic CLK_SYS_IN,                  // System bus clock
    input wire logic RST_N_IN,                    // Async reset, active low
    input wire logic TRANSFER_START_IN,           // Transfer start from other master
    input wire logic [AW-1:0] ADDR_IN,            // Snooped address
    input wire logic [PW-1:0] ADDR_PARITY_IN,     // Odd parity per address byte
    input wire logic [4:0] TRANSFER_TYPE_IN,      // Snooped transfer type
    input wire logic BURST_INDICATOR_IN,          // High for burst transfer
    input wire logic GLOBAL_FLAG_IN,              // Coherency required
    input wire logic [1:0] L1_STATE_IN,           // L1 tag state during lookup
    input wire logic [1:0] L2_STATE_IN,           // L2 tag state during lookup
    input wire logic SNOOP_BUSY_IN,               // Tags unavailable this cycle
    input wire logic FILL_ACTIVE_IN,              // Burst read fill outstanding
    input wire logic [AW-1:0] FILL_ADDR_IN,       // Address of line being filled
    input wire logic WBQ_VALID_IN,                // Write-back queued
    input wire logic WBQ_GRANTED_IN,              // Write-back address tenure done
    input wire logic [AW-1:0] WBQ_ADDR_IN,        // Address of queued write-back
    input wire logic LOAD_RESERVE_SET_IN,         // Load-reserve sets reservation
    input wire logic RESERVE_CLEAR_IN,            // Own store-conditional clears it
    input wire logic [AW-1:0] RESERVE_ADDR_IN,    // Reservation address
    output logic LOOKUP_VALID_OUT,                // Tag lookup strobe
    output logic [AW-1:0] LOOKUP_ADDR_OUT,        // Tag lookup address
    output logic ADDRESS_RETRY_OUT,               // Address retry pulse
    output logic PUSH_REQ_OUT,                    // Push modified block
    output logic STATE_WR_OUT,                    // Write new block state
    output logic [1:0] STATE_WR_VAL_OUT,          // New block state
    output logic [AW-1:0] ACTION_ADDR_OUT,        // Address for push and state write
    output logic RESV_ACTIVE_OUT,                 // Reservation held
    output logic RESV_CANCEL_OUT,                 // Reservation cancelled by snoop
    output logic PARITY_ERR_OUT                   // Snooped address parity bad
);
    import bscr_pkg::*;

    typedef struct packed {
        logic s1_vld;
        logic [AW-1:0] s1_addr;
        bscr_class_t s1_cls;
        logic s1_glb;
        logic s1_rac;
        logic s1_rany;
        logic s1_perr;
        logic retry;
        logic push;
        logic st_wr;
        bscr_mei_t st_val;
        logic [AW-1:0] act_addr;
        logic resv_vld;
        logic [AW-1:0] resv_addr;
        logic resv_cancel;
        logic perr;
    } bscr_state_t;

    localparam bscr_state_t ST_RST = '{
        s1_vld: 1'b0,
        s1_addr: AW'(`BSCR_RST_ADDR),
        s1_cls: CLS_NONE,
        s1_glb: 1'b0,
        s1_rac: 1'b0,
        s1_rany: 1'b0,
        s1_perr: 1'b0,
        retry: 1'b0,
        push: 1'b0,
        st_wr: 1'b0,
        st_val: MEI_I,
        act_addr: AW'(`BSCR_RST_ADDR),
        resv_vld: 1'b0,
        resv_addr: AW'(`BSCR_RST_ADDR),
        resv_cancel: 1'b0,
        perr: 1'b0
    };

    bscr_state_t st_q;
    bscr_state_t st_d;

    bscr_class_t dec_cls;
    logic dec_rac;
    logic dec_rany;
    logic dec_wk;

    logic qual;
    logic act_ok;
    logic fill_col;
    logic wbq_col;
    bscr_mei_t eff;
    logic addr_par_bad;

    // Coherency is per block; anything finer is not compared
    function automatic logic same_blk(input logic [AW-1:0] a, input logic [AW-1:0] b);
        return a[AW-1:BL] == b[AW-1:BL];
    endfunction : same_blk

    function automatic logic parity_bad(input logic [AW-1:0] a, input logic [PW-1:0] p);
        logic bad;
        bad = 1'b0;
        for (int i = 0; i < PW; i++) begin
            bad = bad | ~(^{a[i*`BSCR_LANE_W +: `BSCR_LANE_W], p[i]});
        end
        return bad;
    endfunction : parity_bad

    // Combined L1/L2 state: modified anywhere wins, illegal codes count as miss
    function automatic bscr_mei_t merge_state(input logic [1:0] a, input logic [1:0] b);
        if (a == MEI_M || b == MEI_M) begin
            return MEI_M;
        end else if (a == MEI_E || b == MEI_E) begin
            return MEI_E;
        end
        return MEI_I;
    endfunction : merge_state

    bscr_tt_decode u_dec (
        .tt_in(TRANSFER_TYPE_IN),
        .burst_in(BURST_INDICATOR_IN),
        .class_out(dec_cls),
        .resv_addr_cancel_out(dec_rac),
        .resv_any_cancel_out(dec_rany),
        .write_kill_out(dec_wk)
    );

    // Own writes go out non-global, so only the reservation path sees them
    assign qual = GLOBAL_FLAG_IN || (st_q.resv_vld && dec_wk);

    // Instruction cache is never consulted
    assign eff = merge_state(L1_STATE_IN, L2_STATE_IN);
    assign act_ok = st_q.s1_vld && st_q.s1_glb && st_q.s1_cls != CLS_NONE;
    assign fill_col = FILL_ACTIVE_IN && same_blk(FILL_ADDR_IN, st_q.s1_addr);
    // Once granted, ordering is the memory system's job
    assign wbq_col = WBQ_VALID_IN && !WBQ_GRANTED_IN && same_blk(WBQ_ADDR_IN, st_q.s1_addr);
    assign addr_par_bad = parity_bad(ADDR_IN, ADDR_PARITY_IN);

    always_comb begin
        st_d = st_q;
        // Stage 1: capture at transfer start
        st_d.s1_vld = TRANSFER_START_IN && qual;
        st_d.s1_addr = ADDR_IN;
        st_d.s1_cls = dec_cls;
        st_d.s1_glb = GLOBAL_FLAG_IN;
        st_d.s1_rac = dec_rac;
        st_d.s1_rany = dec_rany;
        st_d.s1_perr = addr_par_bad;
        // Stage 2: answer one cycle after lookup
        st_d.retry = 1'b0;
        st_d.push = 1'b0;
        st_d.st_wr = 1'b0;
        st_d.st_val = MEI_I;
        st_d.act_addr = st_q.s1_addr;
        st_d.resv_cancel = 1'b0;
        st_d.perr = st_q.s1_vld && st_q.s1_perr;
        if (act_ok) begin
            // Busy tags cannot be looked at: retry and leave state alone
            if (SNOOP_BUSY_IN || fill_col || wbq_col) begin
                st_d.retry = 1'b1;
            end
            if (!SNOOP_BUSY_IN) begin
                unique case (st_q.s1_cls)
                    CLS_INV_PUSH: begin
                        if (eff != MEI_I) begin
                            st_d.st_wr = 1'b1;
                            st_d.st_val = MEI_I;
                        end
                        if (eff == MEI_M) begin
                            st_d.retry = 1'b1;
                            st_d.push = 1'b1;
                        end
                    end
                    CLS_INV_DROP: begin
                        // Modified data is discarded on purpose
                        if (eff != MEI_I) begin
                            st_d.st_wr = 1'b1;
                            st_d.st_val = MEI_I;
                        end
                    end
                    CLS_KEEP_PUSH: begin
                        if (eff == MEI_M) begin
                            st_d.retry = 1'b1;
                            st_d.push = 1'b1;
                            st_d.st_wr = 1'b1;
                            st_d.st_val = MEI_E;
                        end
                    end
                    CLS_NONE: begin
                        st_d.st_wr = 1'b0;
                    end
                endcase
            end
        end
        // Reservation: snoop cancel checked even for non-global transfers
        if (st_q.s1_vld && st_q.resv_vld
            && (st_q.s1_rany || (st_q.s1_rac && same_blk(st_q.resv_addr, st_q.s1_addr)))) begin
            st_d.resv_cancel = 1'b1;
        end
        // A new reservation in the same cycle wins over any cancel
        if (LOAD_RESERVE_SET_IN) begin
            st_d.resv_vld = 1'b1;
            st_d.resv_addr = RESERVE_ADDR_IN;
        end else if (st_d.resv_cancel || RESERVE_CLEAR_IN) begin
            st_d.resv_vld = 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            st_q <= ST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign LOOKUP_VALID_OUT = st_q.s1_vld;
    assign LOOKUP_ADDR_OUT = st_q.s1_addr;
    assign ADDRESS_RETRY_OUT = st_q.retry;
    assign PUSH_REQ_OUT = st_q.push;
    assign STATE_WR_OUT = st_q.st_wr;
    assign STATE_WR_VAL_OUT = st_q.st_val;
    assign ACTION_ADDR_OUT = st_q.act_addr;
    assign RESV_ACTIVE_OUT = st_q.resv_vld;
    assign RESV_CANCEL_OUT = st_q.resv_cancel;
    assign PARITY_ERR_OUT = st_q.perr;

    a_global_lookup: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        TRANSFER_START_IN && GLOBAL_FLAG_IN |=> LOOKUP_VALID_OUT
            && LOOKUP_ADDR_OUT == $past(ADDR_IN))
        else $error("global transfer start not looked up");

    a_resv_qualify: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        TRANSFER_START_IN && !GLOBAL_FLAG_IN && RESV_ACTIVE_OUT && dec_wk |=> LOOKUP_VALID_OUT)
        else $error("write or kill under reservation not snooped");

    a_unqual_quiet: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        TRANSFER_START_IN && !GLOBAL_FLAG_IN && !(RESV_ACTIVE_OUT && dec_wk)
            |=> !LOOKUP_VALID_OUT ##1 (!STATE_WR_OUT && !PUSH_REQ_OUT))
        else $error("unqualified transfer caused snoop action");

    a_parity_flag: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        TRANSFER_START_IN && qual |-> ##2 PARITY_ERR_OUT == $past(addr_par_bad, 2))
        else $error("address parity result wrong");

    a_retry_global: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        ADDRESS_RETRY_OUT |-> $past(GLOBAL_FLAG_IN, 2) && $past(TRANSFER_START_IN, 2))
        else $error("retry without global transfer");

    a_fill_retry: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        act_ok && fill_col |=> ADDRESS_RETRY_OUT)
        else $error("pipeline collision not retried");

    a_queue_retry: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        act_ok && wbq_col |=> ADDRESS_RETRY_OUT)
        else $error("write-back queue collision not retried");

    a_granted_quiet: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        act_ok && WBQ_VALID_IN && WBQ_GRANTED_IN && !SNOOP_BUSY_IN && !fill_col && eff != MEI_M
            |=> !ADDRESS_RETRY_OUT)
        else $error("granted write-back still retried");

    a_modified_push: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        act_ok && !SNOOP_BUSY_IN && eff == MEI_M && st_q.s1_cls != CLS_INV_DROP
            |=> ADDRESS_RETRY_OUT && PUSH_REQ_OUT && STATE_WR_OUT)
        else $error("modified hit not retried and pushed");

    a_kill_noretry: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        act_ok && st_q.s1_cls == CLS_INV_DROP && !SNOOP_BUSY_IN && !fill_col && !wbq_col
            && eff != MEI_I |=> !ADDRESS_RETRY_OUT && STATE_WR_OUT && STATE_WR_VAL_OUT == MEI_I)
        else $error("write-kill hit handled wrongly");

    a_keep_exclusive: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        act_ok && st_q.s1_cls == CLS_KEEP_PUSH && eff == MEI_E |=> !STATE_WR_OUT)
        else $error("exclusive block changed by non-caching read");

    a_none_quiet: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        TRANSFER_START_IN && dec_cls == CLS_NONE
            |-> ##2 (!ADDRESS_RETRY_OUT && !PUSH_REQ_OUT && !STATE_WR_OUT))
        else $error("no-action code caused snoop action");

    a_any_cancel: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        LOOKUP_VALID_OUT && st_q.s1_rany && RESV_ACTIVE_OUT && !LOAD_RESERVE_SET_IN
            |=> RESV_CANCEL_OUT && !RESV_ACTIVE_OUT)
        else $error("atomic write-flush left reservation");

    a_busy_retry: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        act_ok && SNOOP_BUSY_IN |=> ADDRESS_RETRY_OUT && !PUSH_REQ_OUT && !STATE_WR_OUT)
        else $error("busy tags not retried");

    a_exclusive_inv: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        act_ok && !SNOOP_BUSY_IN && st_q.s1_cls == CLS_INV_PUSH && eff == MEI_E
            |=> STATE_WR_OUT && STATE_WR_VAL_OUT == MEI_I && !PUSH_REQ_OUT)
        else $error("exclusive block not invalidated");

    a_modified_keep: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        act_ok && !SNOOP_BUSY_IN && st_q.s1_cls == CLS_KEEP_PUSH && eff == MEI_M
            |=> STATE_WR_OUT && STATE_WR_VAL_OUT == MEI_E)
        else $error("modified block not kept exclusive");

    a_addr_cancel: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        LOOKUP_VALID_OUT && st_q.s1_rac && RESV_ACTIVE_OUT
            && same_blk(st_q.resv_addr, LOOKUP_ADDR_OUT) |=> RESV_CANCEL_OUT)
        else $error("matching reservation not cancelled");

    a_miss_quiet: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        act_ok && !SNOOP_BUSY_IN && !fill_col && !wbq_col && eff == MEI_I
            |=> !ADDRESS_RETRY_OUT && !PUSH_REQ_OUT && !STATE_WR_OUT)
        else $error("cache miss caused snoop action");

endmodule : bscr_responder

// ===== bscr_cfg.svh
// Constants of the bus snoop coherency responder
`ifndef BSCR_CFG_SVH
`define BSCR_CFG_SVH

// Bus address width and parity lanes (one odd parity bit per byte)
`define BSCR_ADDR_W 32
`define BSCR_PAR_W 4
`define BSCR_LANE_W 8

// Coherency granule is a 32-byte block: address bits below this are ignored
`define BSCR_BLK_LSB 5

// Snooped transfer type codes
`define BSCR_TT_CLEAN 5'h00
`define BSCR_TT_FLUSH 5'h04
`define BSCR_TT_SYNC 5'h08
`define BSCR_TT_KILL 5'h0C
`define BSCR_TT_ORDER 5'h10
`define BSCR_TT_XCTL_WR 5'h14
`define BSCR_TT_TLB_INV 5'h18
`define BSCR_TT_XCTL_RD 5'h1C
`define BSCR_TT_RESV_SET 5'h01
`define BSCR_TT_TLB_SYNC 5'h09
`define BSCR_TT_IBLK_INV 5'h0D
`define BSCR_TT_WR_FLUSH 5'h02
`define BSCR_TT_WR_KILL 5'h06
`define BSCR_TT_READ 5'h0A
`define BSCR_TT_READ_INTENT_MODIFY 5'h0E
`define BSCR_TT_WR_FLUSH_ATOM 5'h12
`define BSCR_TT_READ_ATOM 5'h1A
`define BSCR_TT_READ_INTENT_MODIFY_ATOM 5'h1E
`define BSCR_TT_READ_NO_CACHE 5'h0B

// Reset values
`define BSCR_RST_ADDR 32'h0000_0000

`endif

// ===== bscr_pkg.sv
// Types shared by the bus snoop coherency responder
`include "bscr_cfg.svh"

package bscr_pkg;

    // Cache block state, three-state protocol
    typedef enum logic [1:0] {
        MEI_I = 2'b00,
        MEI_E = 2'b01,
        MEI_M = 2'b10
    } bscr_mei_t;

    // Snoop action class of a transfer type
    typedef enum logic [1:0] {
        CLS_NONE = 2'b00,      // No cache action
        CLS_INV_PUSH = 2'b01,  // E to I; M retried, pushed, to I
        CLS_KEEP_PUSH = 2'b10, // E stays; M retried, pushed, to E
        CLS_INV_DROP = 2'b11   // Any hit to I, no retry
    } bscr_class_t;

endpackage : bscr_pkg

// ===== bscr_tt_decode.sv
// Transfer type decoder: maps a snooped code to its snoop action
`timescale 1ns/1ps
`include "bscr_cfg.svh"

module bscr_tt_decode (
    input wire logic [4:0] tt_in,                // Snooped transfer type
    input wire logic burst_in,                   // High for a burst transfer
    output bscr_pkg::bscr_class_t class_out,     // Cache action class
    output logic resv_addr_cancel_out,           // Cancel reservation on block match
    output logic resv_any_cancel_out,            // Cancel reservation whatever the address
    output logic write_kill_out                  // Write or kill, qualifies by reservation
);
    import bscr_pkg::*;

    always_comb begin
        class_out = CLS_NONE;
        resv_addr_cancel_out = 1'b0;
        resv_any_cancel_out = 1'b0;
        write_kill_out = 1'b0;
        unique case (tt_in)
            `BSCR_TT_KILL: begin
                class_out = CLS_INV_PUSH;
                resv_addr_cancel_out = 1'b1;
                write_kill_out = 1'b1;
            end
            `BSCR_TT_WR_FLUSH: begin
                class_out = CLS_INV_PUSH;
                resv_addr_cancel_out = 1'b1;
                write_kill_out = 1'b1;
            end
            `BSCR_TT_WR_KILL: begin
                class_out = CLS_INV_DROP;
                resv_addr_cancel_out = 1'b1;
                write_kill_out = 1'b1;
            end
            `BSCR_TT_READ, `BSCR_TT_READ_ATOM: begin
                // Single-beat reads count as caching inhibited
                class_out = burst_in ? CLS_INV_PUSH : CLS_KEEP_PUSH;
            end
            `BSCR_TT_READ_INTENT_MODIFY, `BSCR_TT_READ_INTENT_MODIFY_ATOM: begin
                class_out = CLS_INV_PUSH;
            end
            `BSCR_TT_WR_FLUSH_ATOM: begin
                class_out = CLS_INV_PUSH;
                resv_any_cancel_out = 1'b1;
                write_kill_out = 1'b1;
            end
            `BSCR_TT_READ_NO_CACHE: begin
                class_out = CLS_KEEP_PUSH;
            end
            default: begin
                // No-action and reserved codes
                class_out = CLS_NONE;
            end
        endcase
    end

endmodule : bscr_tt_decode

// ===== bscr_mem_model.sv
// Tag store and system side model facing the snoop responder
`timescale 1ns/1ps
module bscr_mem_model (
    input wire logic clk_in,             // Bus clock
    input wire logic rst_n_in,           // Async reset, active low
    input wire logic ts_in,              // Transfer start seen on the bus
    input wire logic lk_valid_in,        // Tag lookup strobe
    input wire logic [31:0] lk_addr_in,  // Tag lookup address
    input wire logic wr_in,              // State write strobe
    input wire logic [1:0] wr_val_in,    // New block state
    input wire logic [31:0] act_addr_in, // State write address
    output logic [1:0] l1_out,           // L1 tag state
    output logic [1:0] l2_out,           // L2 tag state
    output logic ack_out                 // Address acknowledge
);
    logic [1:0] l1_q [0:7];
    logic [1:0] l2_q [0:7];
    logic tog_q;
    // Junk outside a lookup so a stray sample shows up
    assign l1_out = lk_valid_in ? l1_q[lk_addr_in[7:5]] : {tog_q, ~tog_q};
    assign l2_out = lk_valid_in ? l2_q[lk_addr_in[7:5]] : {~tog_q, tog_q};
    task automatic set_blk(input logic [2:0] idx, input logic [1:0] s1, input logic [1:0] s2);
        l1_q[idx] = s1;
        l2_q[idx] = s2;
    endtask : set_blk
    // Acknowledge each transfer start and apply state writes to both tag levels
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tog_q <= 1'h0;
            ack_out <= 1'h0;
        end else begin
            tog_q <= ~tog_q;
            ack_out <= ts_in;
            if (wr_in) begin
                l1_q[act_addr_in[7:5]] <= wr_val_in;
                l2_q[act_addr_in[7:5]] <= wr_val_in;
            end
        end
    end
endmodule : bscr_mem_model

// ===== bscr_responder_tb_top.sv
// Self-checking bench of the snoop coherency responder
`timescale 1ns/1ps
`include "bscr_cfg.svh"
module bscr_responder_tb_top;
    localparam logic [31:0] BLK_A = 32'h0000_1040;
    localparam logic [31:0] BLK_B = 32'h0000_20A0;
    logic clk, rst_n, ts, burst, global_flag, busy, fill, wbq_v, wbq_g, rset, rclr;
    logic [31:0] addr, fill_addr, wbq_addr, raddr, lk_a, act_a;
    logic [3:0] par;
    logic [4:0] tt;
    logic [1:0] l1s, l2s, sval;
    logic lk_v, retry, push, swr, ractive, rcancel, perr, ack;
    int n_mismatch = 0;
    int check_count = 0;

    bscr_responder DUT (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .TRANSFER_START_IN(ts),
        .ADDR_IN(addr), .ADDR_PARITY_IN(par), .TRANSFER_TYPE_IN(tt), .BURST_INDICATOR_IN(burst),
        .GLOBAL_FLAG_IN(global_flag), .L1_STATE_IN(l1s), .L2_STATE_IN(l2s), .SNOOP_BUSY_IN(busy),
        .FILL_ACTIVE_IN(fill), .FILL_ADDR_IN(fill_addr), .WBQ_VALID_IN(wbq_v),
        .WBQ_GRANTED_IN(wbq_g), .WBQ_ADDR_IN(wbq_addr), .LOAD_RESERVE_SET_IN(rset),
        .RESERVE_CLEAR_IN(rclr), .RESERVE_ADDR_IN(raddr), .LOOKUP_VALID_OUT(lk_v),
        .LOOKUP_ADDR_OUT(lk_a), .ADDRESS_RETRY_OUT(retry), .PUSH_REQ_OUT(push),
        .STATE_WR_OUT(swr), .STATE_WR_VAL_OUT(sval), .ACTION_ADDR_OUT(act_a),
        .RESV_ACTIVE_OUT(ractive), .RESV_CANCEL_OUT(rcancel), .PARITY_ERR_OUT(perr));

    bscr_mem_model u_mem (.clk_in(clk), .rst_n_in(rst_n), .ts_in(ts), .lk_valid_in(lk_v),
        .lk_addr_in(lk_a), .wr_in(swr), .wr_val_in(sval), .act_addr_in(act_a),
        .l1_out(l1s), .l2_out(l2s), .ack_out(ack));

    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end

    task automatic finish_test();
        $display("Checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    function automatic logic [3:0] oddp(input logic [31:0] a);
        for (int i = 0; i < 4; i++) oddp[i] = ~^a[8*i +: 8];
    endfunction : oddp

    // Action class: 0 none, 1 invalidate with push, 2 keep with push, 3 drop
    function automatic logic [1:0] cls(input logic [4:0] c, input logic b);
        case (c)
            `BSCR_TT_KILL, `BSCR_TT_WR_FLUSH, `BSCR_TT_READ_INTENT_MODIFY,
            `BSCR_TT_WR_FLUSH_ATOM, `BSCR_TT_READ_INTENT_MODIFY_ATOM: cls = 2'h1;
            `BSCR_TT_READ, `BSCR_TT_READ_ATOM: cls = b ? 2'h1 : 2'h2;
            `BSCR_TT_READ_NO_CACHE: cls = 2'h2;
            `BSCR_TT_WR_KILL: cls = 2'h3;
            default: cls = 2'h0;
        endcase
    endfunction : cls

    // Expected {retry, push, state write, state value}
    function automatic logic [4:0] act(input logic [1:0] cl, input logic [1:0] st);
        logic m;
        logic h;
        m = (st == 2'h2);
        h = m | (st == 2'h1);
        case (cl)
            2'h1: act = {m, m, h, 2'h0};
            2'h2: act = {m, m, m, 1'h0, m};
            2'h3: act = {2'h0, h, 2'h0};
            default: act = 5'h00;
        endcase
    endfunction : act

    // Expectation e = {lookup, retry, push, wr, val[1:0], cancel, parity error}
    task automatic snoop(input logic [4:0] c, input logic b, input logic g, input logic [31:0] a,
            input logic bad, input logic [1:0] s1, input logic [1:0] s2, input logic [7:0] e);
        logic lv;
        @(posedge clk);
        #5;
        u_mem.set_blk(a[7:5], s1, s2);
        ts = 1'h1;
        tt = c;
        burst = b;
        global_flag = g;
        addr = a;
        par = oddp(a) ^ {3'h0, bad};
        @(posedge clk);
        #5;
        ts = 1'h0;
        lv = lk_v;
        chk(ack, 32'h1, "address acknowledge");
        if (lv === 1'h1) chk(lk_a, a, "lookup address");
        @(posedge clk);
        #5;
        chk({lv, retry, push, swr, swr ? sval : 2'h0, rcancel, perr}, e, "answer");
        if (swr === 1'h1) chk(act_a, a, "action address");
    endtask : snoop

    task automatic resv(input logic s, input logic c, input logic [31:0] a, input logic exp);
        @(posedge clk);
        #5;
        rset = s;
        rclr = c;
        raddr = a;
        @(posedge clk);
        #5;
        rset = 1'h0;
        rclr = 1'h0;
        chk(ractive, exp, "reservation active");
    endtask : resv

    task automatic t_codes();
        for (int c = 0; c < 32; c++) begin
            for (int b = 0; b < 2; b++) begin
                for (int s = 0; s < 3; s++) begin
                    snoop(c[4:0], b[0], 1'h1, BLK_A, 1'h0, s[1:0], 2'h0,
                        {1'h1, act(cls(c[4:0], b[0]), s[1:0]), 2'h0});
                end
            end
        end
    endtask : t_codes

    task automatic t_sources();
        snoop(`BSCR_TT_READ_INTENT_MODIFY, 1'h1, 1'h1, BLK_B, 1'h0, 2'h0, 2'h2, 8'hF0);
        snoop(`BSCR_TT_READ_INTENT_MODIFY, 1'h1, 1'h0, BLK_A, 1'h0, 2'h2, 2'h2, 8'h00);
        snoop(`BSCR_TT_READ, 1'h1, 1'h1, BLK_A, 1'h1, 2'h0, 2'h0, 8'h81);
        busy = 1'h1;
        snoop(`BSCR_TT_KILL, 1'h0, 1'h1, BLK_A, 1'h0, 2'h0, 2'h0, 8'hC0);
        snoop(`BSCR_TT_KILL, 1'h0, 1'h0, BLK_A, 1'h0, 2'h2, 2'h0, 8'h00);
        snoop(`BSCR_TT_SYNC, 1'h0, 1'h1, BLK_A, 1'h0, 2'h0, 2'h0, 8'h80);
        busy = 1'h0;
        fill = 1'h1;
        fill_addr = BLK_A + 32'h0000_0018;
        snoop(`BSCR_TT_READ, 1'h1, 1'h1, BLK_A, 1'h0, 2'h0, 2'h0, 8'hC0);
        snoop(`BSCR_TT_READ, 1'h1, 1'h1, BLK_B, 1'h0, 2'h0, 2'h0, 8'h80);
        fill = 1'h0;
        wbq_v = 1'h1;
        wbq_addr = BLK_A + 32'h0000_0004;
        snoop(`BSCR_TT_READ_NO_CACHE, 1'h0, 1'h1, BLK_A, 1'h0, 2'h1, 2'h0, 8'hC0);
        wbq_g = 1'h1;
        snoop(`BSCR_TT_READ_NO_CACHE, 1'h0, 1'h1, BLK_A, 1'h0, 2'h1, 2'h0, 8'h80);
        wbq_v = 1'h0;
        wbq_g = 1'h0;
    endtask : t_sources

    task automatic t_resv();
        resv(1'h1, 1'h0, BLK_A, 1'h1);
        snoop(`BSCR_TT_READ, 1'h1, 1'h0, BLK_A, 1'h0, 2'h2, 2'h0, 8'h00);
        snoop(`BSCR_TT_KILL, 1'h0, 1'h0, BLK_B, 1'h0, 2'h2, 2'h0, 8'h80);
        snoop(`BSCR_TT_WR_KILL, 1'h1, 1'h0, BLK_A, 1'h1, 2'h2, 2'h2, 8'h83);
        resv(1'h0, 1'h0, BLK_A, 1'h0);
        resv(1'h1, 1'h0, BLK_A, 1'h1);
        snoop(`BSCR_TT_WR_FLUSH_ATOM, 1'h0, 1'h1, BLK_B, 1'h0, 2'h0, 2'h0, 8'h82);
        resv(1'h1, 1'h0, BLK_B, 1'h1);
        resv(1'h0, 1'h1, BLK_B, 1'h0);
        resv(1'h1, 1'h0, BLK_A, 1'h1);
        snoop(`BSCR_TT_KILL, 1'h0, 1'h1, BLK_A, 1'h0, 2'h1, 2'h0, 8'h92);
        resv(1'h1, 1'h0, BLK_B, 1'h1);
        snoop(`BSCR_TT_WR_FLUSH, 1'h1, 1'h1, BLK_B, 1'h0, 2'h2, 2'h0, 8'hF2);
    endtask : t_resv

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        finish_test();
    end

    initial begin
        {rst_n, ts, burst, global_flag, busy, fill, wbq_v, wbq_g, rset, rclr} = 10'h000;
        {addr, fill_addr, wbq_addr, raddr} = 128'h0;
        par = 4'hF;
        tt = 5'h00;
        repeat (20) @(posedge clk);
        chk({lk_v, retry, push, swr, rcancel, perr, ractive}, 32'h0, "reset");
        #5;
        rst_n = 1'h1;
        t_codes();
        t_sources();
        t_resv();
        finish_test();
    end
endmodule : bscr_responder_tb_top
